// [pkg/ssf_pkg.sv]
// Package with register addresses, flag positions, reset values and timing for the SPI flag block.
// What this block does
// - Bit 7 high while port transfers data.
// - Slave select seen during master transfer sets bit 6.
// - Writing zero clears multimaster error flag.
// - Unread buffer at next byte end sets bit 5.
// - Overwrite option replaces buffer on overflow.
// - New received byte sets bit 4, interrupts.
// - Mode zero: unread buffer halts transfer, releases select.
// - Bit 3 shows receive buffer full.
// - Bit 2 flags transmit underflow, zero clears.
// - Bit 1 set when transmit buffer empties.
// - No new transmit data ends a master transfer.
// - Mode one: writing zero clears bit 1.
// - Bit 0 shows transmit buffer full.
package ssf_pkg;

  // Core register addresses.
  localparam logic [7:0] ADDR_STATUS   = 8'hea;
  localparam logic [7:0] ADDR_TX_BUF   = 8'h9a;
  localparam logic [7:0] ADDR_RX_BUF   = 8'h9b;

  // Status flag bit positions.
  localparam int BIT_BUSY      = 7;
  localparam int BIT_MM_ERR    = 6;
  localparam int BIT_RX_OVF    = 5;
  localparam int BIT_RX_IRQ    = 4;
  localparam int BIT_RX_FULL   = 3;
  localparam int BIT_TX_UNDER  = 2;
  localparam int BIT_TX_IRQ    = 1;
  localparam int BIT_TX_FULL   = 0;

  // Reset values.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET    = 8'h00;

  // Serial clock timing in master mode.
  localparam int  CLK_PERIOD_NS   = 20;
  localparam int  SCLK_HALF_NS    = 160;
  localparam int  SCLK_HALF_CYC   = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  BITS_PER_BYTE   = 8;

  // Transfer engine states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MST_LOW,
    ST_MST_HIGH,
    ST_SLV_XFER,
    ST_SLV_HALT
  } ssf_state_t;

endpackage : ssf_pkg

// [hdl/ssf_sync.sv]
// Two-stage synchroniser for inputs arriving from outside the core clock domain.
`timescale 1ns/1ps
module ssf_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic [WIDTH-1:0] D,
  output logic      [WIDTH-1:0] Q
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_q <= '0;
      Q      <= '0;
    end else begin
      meta_q <= D;
      Q      <= meta_q;
    end
  end

endmodule : ssf_sync

// [hdl/ssf_spi_flags.sv]
// SPI port with double-buffered data and the status flag register seen by the core.
`timescale 1ns/1ps
module ssf_spi_flags #(
  parameter int HALF_CYC = ssf_pkg::SCLK_HALF_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  // Core register port.
  input  wire logic [7:0] SFR_ADDR,
  input  wire logic       SFR_WR,
  input  wire logic       SFR_RD,
  input  wire logic [7:0] SFR_WDATA,
  output logic      [7:0] SFR_RDATA,
  // Configuration levels from the configuration registers.
  input  wire logic       MASTER_MODE,
  input  wire logic       SS_INPUT_ENABLE,
  input  wire logic       OVERFLOW_OVERWRITE_ENABLE,
  input  wire logic       INTERRUPT_MODE_SELECT,
  input  wire logic       SERIAL_IRQ_ENABLE,
  output logic            SERIAL_IRQ,
  // Serial pins, each split into input, output and output enable.
  input  wire logic       SCLK_I,
  output logic            SCLK_O,
  output logic            SCLK_OE,
  input  wire logic       MOSI_I,
  output logic            MOSI_O,
  output logic            MOSI_OE,
  input  wire logic       MISO_I,
  output logic            MISO_O,
  output logic            MISO_OE,
  input  wire logic       SS_N_I,
  output logic            SS_N_O,
  output logic            SS_N_OE
);

  ssf_pkg::ssf_state_t state_q;
  logic [7:0]          shift_q;
  logic                rx_bit_q;
  logic [2:0]          bit_cnt_q;
  logic [15:0]         div_q;
  logic [7:0]          transmit_buffer_q;
  logic [7:0]          receive_buffer_q;
  logic                sclk_prev_q;
  logic                ss_n_out_q;
  logic                multimaster_error_flag_q;
  logic                rx_overflow_flag_q;
  logic                rx_interrupt_flag_q;
  logic                rx_buffer_full_flag_q;
  logic                tx_underflow_flag_q;
  logic                tx_interrupt_flag_q;
  logic                tx_buffer_full_flag_q;
  logic [7:0]          rdata_q;
  logic [3:0]          pins_sync;
  logic                sclk_s;
  logic                mosi_s;
  logic                miso_s;
  logic                ss_n_s;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                div_done;
  logic                sample_edge;
  logic                shift_edge;
  logic                end_edge;
  logic                serial_in;
  logic                byte_done;
  logic [7:0]          byte_rx;
  logic                load_tx;
  logic                start_mst;
  logic                stop_xfer;
  logic                wr_status;
  logic                wr_tx;
  logic                rd_rx;
  logic                busy;
  logic [7:0]          status;

  // Every pin input passes two flip-flops before use.
  ssf_sync #(
    .WIDTH (4)
  ) u_sync (
    .CLK (CLK),
    .RST (RST),
    .D   ({SCLK_I, MOSI_I, MISO_I, SS_N_I}),
    .Q   (pins_sync)
  );

  assign sclk_s = pins_sync[3];
  assign mosi_s = pins_sync[2];
  assign miso_s = pins_sync[1];
  assign ss_n_s = pins_sync[0];

  // Edge detection on the synchronised slave clock.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  // Core access decode.
  assign wr_status = SFR_WR & (SFR_ADDR == ssf_pkg::ADDR_STATUS);
  assign wr_tx     = SFR_WR & (SFR_ADDR == ssf_pkg::ADDR_TX_BUF);
  assign rd_rx     = SFR_RD & (SFR_ADDR == ssf_pkg::ADDR_RX_BUF);

  // Bit timing: a rise samples, a fall shifts, and a byte ends on its last fall.
  // Ending on the fall keeps the next top bit from moving while the far side samples.
  assign div_done    = (div_q == 16'h0000);
  assign sample_edge = (state_q == ssf_pkg::ST_MST_LOW && div_done) ||
                       (state_q == ssf_pkg::ST_SLV_XFER && sclk_rise);
  assign end_edge    = (state_q == ssf_pkg::ST_MST_HIGH && div_done) ||
                       (state_q == ssf_pkg::ST_SLV_XFER && sclk_fall);
  assign shift_edge  = end_edge && (bit_cnt_q != 3'h0);
  assign serial_in   = MASTER_MODE ? miso_s : mosi_s;
  assign byte_done   = end_edge && (bit_cnt_q == 3'h0);
  assign byte_rx     = {shift_q[6:0], rx_bit_q};

  // A byte ends in master mode when the buffer stays unread in mode zero or no new data waits.
  assign stop_xfer = byte_done &&
                     ((~INTERRUPT_MODE_SELECT && rx_buffer_full_flag_q) ||
                      (MASTER_MODE && ~tx_buffer_full_flag_q));

  // A master start waits while mode zero still holds an unread byte.
  assign start_mst = MASTER_MODE && tx_buffer_full_flag_q &&
                     ~(~INTERRUPT_MODE_SELECT && rx_buffer_full_flag_q);

  // Transmit data moves into the shift register at a start or at each byte boundary.
  assign load_tx = tx_buffer_full_flag_q &&
                   ((state_q == ssf_pkg::ST_IDLE && start_mst) ||
                    (state_q == ssf_pkg::ST_IDLE && ~MASTER_MODE && ~ss_n_s) ||
                    (byte_done && ~stop_xfer));

  // Transfer engine for master and slave operation.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ssf_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        ssf_pkg::ST_IDLE: begin
          if (start_mst) begin
            state_q <= ssf_pkg::ST_MST_LOW;
          end else if (~MASTER_MODE && ~ss_n_s) begin
            state_q <= ssf_pkg::ST_SLV_XFER;
          end
        end
        ssf_pkg::ST_MST_LOW: begin
          if (div_done) begin
            state_q <= ssf_pkg::ST_MST_HIGH;
          end
        end
        ssf_pkg::ST_MST_HIGH: begin
          if (stop_xfer) begin
            state_q <= ssf_pkg::ST_IDLE;
          end else if (div_done) begin
            state_q <= ssf_pkg::ST_MST_LOW;
          end
        end
        ssf_pkg::ST_SLV_XFER: begin
          if (ss_n_s) begin
            state_q <= ssf_pkg::ST_IDLE;
          end else if (stop_xfer) begin
            state_q <= ssf_pkg::ST_SLV_HALT;
          end
        end
        ssf_pkg::ST_SLV_HALT: begin
          if (ss_n_s) begin
            state_q <= ssf_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Half-period counter for the master serial clock.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_q <= 16'h0000;
    end else if (state_q == ssf_pkg::ST_IDLE || div_done) begin
      div_q <= 16'(HALF_CYC - 1);
    end else begin
      div_q <= div_q - 16'h0001;
    end
  end

  // Bit counter and shift register.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shift_q   <= ssf_pkg::BUF_RESET;
      rx_bit_q  <= 1'b0;
      bit_cnt_q <= 3'h0;
    end else if (state_q == ssf_pkg::ST_IDLE) begin
      bit_cnt_q <= 3'h0;
      if (load_tx) begin
        shift_q <= transmit_buffer_q;
      end
    end else begin
      if (sample_edge) begin
        rx_bit_q  <= serial_in;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (byte_done) begin
        shift_q <= transmit_buffer_q;
      end else if (shift_edge) begin
        shift_q <= {shift_q[6:0], rx_bit_q};
      end
    end
  end

  // Transmit buffer holds the last value written by the core.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      transmit_buffer_q <= ssf_pkg::BUF_RESET;
    end else if (wr_tx) begin
      transmit_buffer_q <= SFR_WDATA;
    end
  end

  // Receive buffer takes a byte unless it is unread and overwrite is off.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      receive_buffer_q <= ssf_pkg::BUF_RESET;
    end else if (byte_done && (~rx_buffer_full_flag_q || OVERFLOW_OVERWRITE_ENABLE)) begin
      receive_buffer_q <= byte_rx;
    end
  end

  // Receive flags; a new byte wins over a read in the same cycle.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_overflow_flag_q    <= 1'b0;
      rx_interrupt_flag_q   <= 1'b0;
      rx_buffer_full_flag_q <= 1'b0;
    end else begin
      if (byte_done && rx_buffer_full_flag_q) begin
        rx_overflow_flag_q <= 1'b1;
      end else if (rd_rx) begin
        rx_overflow_flag_q <= 1'b0;
      end
      if (byte_done) begin
        rx_interrupt_flag_q   <= 1'b1;
        rx_buffer_full_flag_q <= 1'b1;
      end else if (rd_rx) begin
        rx_interrupt_flag_q   <= 1'b0;
        rx_buffer_full_flag_q <= 1'b0;
      end
    end
  end

  // Transmit flags; hardware events win over core clears.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_underflow_flag_q   <= 1'b0;
      tx_interrupt_flag_q   <= 1'b0;
      tx_buffer_full_flag_q <= 1'b0;
    end else begin
      if (byte_done && ~tx_buffer_full_flag_q) begin
        tx_underflow_flag_q <= 1'b1;
      end else if (wr_status && ~SFR_WDATA[ssf_pkg::BIT_TX_UNDER]) begin
        tx_underflow_flag_q <= 1'b0;
      end
      if (load_tx) begin
        tx_interrupt_flag_q <= 1'b1;
      end else if (wr_tx) begin
        tx_interrupt_flag_q <= 1'b0;
      end else if (wr_status && INTERRUPT_MODE_SELECT &&
                   ~SFR_WDATA[ssf_pkg::BIT_TX_IRQ]) begin
        tx_interrupt_flag_q <= 1'b0;
      end
      if (wr_tx) begin
        tx_buffer_full_flag_q <= 1'b1;
      end else if (load_tx) begin
        tx_buffer_full_flag_q <= 1'b0;
      end else if (wr_status && ~SFR_WDATA[ssf_pkg::BIT_TX_FULL]) begin
        tx_buffer_full_flag_q <= 1'b0;
      end
    end
  end

  // Multimaster error: select driven low by another master during a master transfer.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      multimaster_error_flag_q <= 1'b0;
    end else if (SS_INPUT_ENABLE && ~ss_n_s &&
                 (state_q == ssf_pkg::ST_MST_LOW || state_q == ssf_pkg::ST_MST_HIGH)) begin
      multimaster_error_flag_q <= 1'b1;
    end else if (wr_status && ~SFR_WDATA[ssf_pkg::BIT_MM_ERR]) begin
      multimaster_error_flag_q <= 1'b0;
    end
  end

  // Busy covers every state that moves data; a halted slave is idle.
  assign busy = (state_q == ssf_pkg::ST_MST_LOW) || (state_q == ssf_pkg::ST_MST_HIGH) ||
                (state_q == ssf_pkg::ST_SLV_XFER);

  // The eight flags gathered into the status byte.
  assign status = {busy, multimaster_error_flag_q, rx_overflow_flag_q, rx_interrupt_flag_q,
                   rx_buffer_full_flag_q, tx_underflow_flag_q, tx_interrupt_flag_q,
                   tx_buffer_full_flag_q};

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= ssf_pkg::STATUS_RESET;
    end else if (SFR_RD) begin
      if (SFR_ADDR == ssf_pkg::ADDR_STATUS) begin
        rdata_q <= status;
      end else if (SFR_ADDR == ssf_pkg::ADDR_RX_BUF) begin
        rdata_q <= receive_buffer_q;
      end else if (SFR_ADDR == ssf_pkg::ADDR_TX_BUF) begin
        rdata_q <= transmit_buffer_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign SFR_RDATA = rdata_q;

  // Interrupt request from either interrupt flag when the shared enable is set.
  assign SERIAL_IRQ = SERIAL_IRQ_ENABLE & (rx_interrupt_flag_q | tx_interrupt_flag_q);

  // Master select output goes low for a master transfer and high when it stops.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ss_n_out_q <= 1'b1;
    end else begin
      ss_n_out_q <= ~((state_q == ssf_pkg::ST_MST_LOW || state_q == ssf_pkg::ST_MST_HIGH) &&
                      ~stop_xfer);
    end
  end

  // Pin drive: master owns clock and data out, and select while the select input is off; slave drives its output only when selected.
  assign SCLK_O  = (state_q == ssf_pkg::ST_MST_HIGH);
  assign SCLK_OE = MASTER_MODE;
  assign MOSI_O  = shift_q[7];
  assign MOSI_OE = MASTER_MODE;
  assign MISO_O  = shift_q[7];
  assign MISO_OE = (state_q == ssf_pkg::ST_SLV_XFER);
  assign SS_N_O  = ss_n_out_q;
  assign SS_N_OE = MASTER_MODE & ~SS_INPUT_ENABLE;

endmodule : ssf_spi_flags

// [sim/ssf_spi_flags_checker.sv]
// Concurrent checks on the ports of the SPI flag block.
`timescale 1ns/1ps
module ssf_spi_flags_checker #(
  parameter int HALF_CYC = 4
) (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic       SFR_WR,
  input wire logic       SFR_RD,
  input wire logic [7:0] SFR_RDATA,
  input wire logic       MASTER_MODE,
  input wire logic       SS_INPUT_ENABLE,
  input wire logic       INTERRUPT_MODE_SELECT,
  input wire logic       SERIAL_IRQ_ENABLE,
  input wire logic       SERIAL_IRQ,
  input wire logic       SCLK_O,
  input wire logic       SCLK_OE,
  input wire logic       MOSI_OE,
  input wire logic       SS_N_O,
  input wire logic       SS_N_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [7:0] hi_q;
  logic       mapped;
  // Counts the cycles of the current high half of the serial clock.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) hi_q <= 8'h00;
    else hi_q <= SCLK_O ? hi_q + 8'h01 : 8'h00;
  end
  // Marks the three decoded register addresses.
  assign mapped = SFR_ADDR inside {ssf_pkg::ADDR_STATUS, ssf_pkg::ADDR_TX_BUF,
                                   ssf_pkg::ADDR_RX_BUF};
  a_unmapped_reads_zero: assert property (SFR_RD && !mapped |=> SFR_RDATA == 8'h00)
    else $error("unmapped read gave nonzero data");
  a_rdata_holds: assert property (!SFR_RD |=> $stable(SFR_RDATA))
    else $error("read data changed without a read");
  a_irq_needs_enable: assert property (SERIAL_IRQ |-> SERIAL_IRQ_ENABLE)
    else $error("interrupt request while disabled");
  a_pin_enables: assert property (SCLK_OE == MASTER_MODE && MOSI_OE == MASTER_MODE &&
    SS_N_OE == (MASTER_MODE && !SS_INPUT_ENABLE))
    else $error("pin enables do not follow the mode");
  a_sclk_idle_low: assert property (SS_N_OE && SS_N_O && $past(SS_N_O) |-> !SCLK_O)
    else $error("serial clock moves while deselected");
  a_sclk_high_half: assert property ($fell(SCLK_O) |-> hi_q == HALF_CYC)
    else $error("serial clock high half has wrong length");
  a_select_starts: assert property (SFR_WR && SFR_ADDR == ssf_pkg::ADDR_TX_BUF &&
    INTERRUPT_MODE_SELECT && SS_N_OE && SS_N_O && $past(SS_N_O) && $past(SS_N_O, 2)
    |-> ##[1:4] !SS_N_O)
    else $error("transfer did not start after a transmit write");
  a_sclk_while_selected: assert property (SCLK_O && SS_N_OE |-> !SS_N_O)
    else $error("serial clock high while deselected");
  a_rx_read_clears: assert property (SFR_RD && SFR_ADDR == ssf_pkg::ADDR_RX_BUF &&
    SS_N_OE && SS_N_O && $past(SS_N_O) ##1 SFR_RD && SFR_ADDR == ssf_pkg::ADDR_STATUS
    |=> SFR_RDATA[5:3] == 3'h0)
    else $error("receive flags survive a buffer read");
  c_byte_end: cover property ($rose(SS_N_O));
  c_irq: cover property ($rose(SERIAL_IRQ));
  c_unmapped: cover property (SFR_RD && !mapped);
endmodule : ssf_spi_flags_checker

bind ssf_spi_flags ssf_spi_flags_checker #(.HALF_CYC(HALF_CYC)) u_ssf_spi_flags_checker (
  .CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .SFR_RDATA(SFR_RDATA), .MASTER_MODE(MASTER_MODE), .SS_INPUT_ENABLE(SS_INPUT_ENABLE),
  .INTERRUPT_MODE_SELECT(INTERRUPT_MODE_SELECT), .SERIAL_IRQ_ENABLE(SERIAL_IRQ_ENABLE),
  .SERIAL_IRQ(SERIAL_IRQ), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE), .MOSI_OE(MOSI_OE),
  .SS_N_O(SS_N_O), .SS_N_OE(SS_N_OE));

// [sim/ssf_slave_model.sv]
// Behavioural SPI slave in clock mode zero that answers the port as master.
`timescale 1ns/1ps
module ssf_slave_model (
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh;
  logic [2:0] n;
  initial begin
    miso = 1'b1;
    rx_byte = 8'h00;
  end
  // Selection loads the byte and presents its top bit before the first edge.
  always @(negedge ss_n) begin
    sh = tx_byte;
    n = 3'h0;
    miso = tx_byte[7];
  end
  // Deselected, the line no longer holds the last bit.
  always @(posedge ss_n) miso = ~miso;
  // Incoming bits are taken on the rising edge, top bit first.
  always @(posedge sclk) if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
  // Outgoing bits shift on the falling edge; a new byte reloads after eight.
  always @(negedge sclk) if (!ss_n) begin
    n = n + 3'h1;
    sh = (n == 3'h0) ? tx_byte : {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule : ssf_slave_model

// [sim/ssf_spi_flags_tb.sv]
// Self-checking bench for the SPI flag block running as master and as slave.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, e, a); end end
module ssf_spi_flags_tb;
  localparam int HC = 4;
  localparam logic [7:0] ST = ssf_pkg::ADDR_STATUS;
  localparam logic [7:0] TX = ssf_pkg::ADDR_TX_BUF;
  localparam logic [7:0] RX = ssf_pkg::ADDR_RX_BUF;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, ow = 0, ssie = 0, ims = 1, irqen = 0;
  logic       ss_ext = 1, irq, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic       mm = 1, sclk_ext = 0, mosi_ext = 0;
  logic       ss_o, ss_oe, m_miso;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, d, sb = 8'h00, m_rx;
  int         failures = 0, n_checks = 0;
  wire sclk_w = sclk_oe ? sclk_o : sclk_ext;
  wire mosi_w = mosi_oe ? mosi_o : mosi_ext;
  wire miso_w = miso_oe ? miso_o : m_miso;
  wire ss_w   = ss_oe ? ss_o : ss_ext;
  // Core clock of 20 ns.
  always #10 clk = ~clk;
  ssf_spi_flags #(.HALF_CYC(HC)) u_ssf_spi_flags (
    .CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata),
    .SFR_RDATA(rdata), .MASTER_MODE(mm), .SS_INPUT_ENABLE(ssie),
    .OVERFLOW_OVERWRITE_ENABLE(ow), .INTERRUPT_MODE_SELECT(ims), .SERIAL_IRQ_ENABLE(irqen),
    .SERIAL_IRQ(irq), .SCLK_I(sclk_w), .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .MOSI_I(mosi_w),
    .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o),
    .MISO_OE(miso_oe), .SS_N_I(ss_w), .SS_N_O(ss_o), .SS_N_OE(ss_oe));
  ssf_slave_model u_ssf_slave_model (
    .sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .tx_byte(sb), .miso(m_miso), .rx_byte(m_rx));
  // Drives one cycle of the register port from a falling edge.
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] dt);
    @(negedge clk);
    wr = w;
    rd = r;
    addr = a;
    wdata = dt;
  endtask : acc
  task automatic rdr(input logic [7:0] a, output logic [7:0] q);
    acc(1'b0, 1'b1, a, 8'h00);
    acc(1'b0, 1'b0, a, 8'h00);
    q = rdata;
  endtask : rdr
  task automatic wrr(input logic [7:0] a, input logic [7:0] dt);
    acc(1'b1, 1'b0, a, dt);
    acc(1'b0, 1'b0, a, dt);
  endtask : wrr
  // Waits for n serial clock high halves to end, then lets the flags settle.
  task automatic falls(input int n);
    repeat (n) @(negedge sclk_o);
    repeat (4) @(negedge clk);
  endtask : falls
  // Clocks one byte in as an outside master and reads the port's answer on each rise.
  task automatic sbyte(input logic [7:0] b, output logic [7:0] q);
    for (int k = 7; k >= 0; k--) begin
      mosi_ext = b[k];
      repeat (4) @(negedge clk);
      sclk_ext = 1;
      q = {q[6:0], miso_w};
      repeat (4) @(negedge clk);
      sclk_ext = 0;
    end
  endtask : sbyte
  // Status after a byte that left the transmit buffer empty.
  function automatic logic [7:0] st_exp(input logic ovf);
    return {2'b00, ovf, 5'b11110};
  endfunction : st_exp
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end
  // Main sequence of scenarios.
  initial begin
    void'($urandom(40));
    repeat (12) @(negedge clk);
    rst = 0;
    rdr(ST, v);
    `CHK("status after reset", ssf_pkg::STATUS_RESET, v)
    rdr(8'h55, v);
    `CHK("unmapped read", 8'h00, v)
    for (int i = 0; i < 4; i++) begin
      irqen = 1'($urandom);
      sb = (i == 3) ? 8'h00 : 8'($urandom);
      d = (i == 3) ? 8'hff : 8'($urandom);
      wrr(TX, d);
      falls(3);
      rdr(ST, v);
      `CHK("busy", 1'b1, v[7])
      falls(5);
      `CHK("select released", 1'b1, ss_o)
      `CHK("irq line", irqen, irq)
      `CHK("mosi byte", d, m_rx)
      rdr(ST, v);
      `CHK("status after byte", st_exp(1'b0), v)
      acc(1'b0, 1'b1, RX, 8'h00);
      acc(1'b0, 1'b1, ST, 8'h00);
      `CHK("receive buffer", sb, rdata)
      acc(1'b0, 1'b0, ST, 8'h00);
      `CHK("status after read", 8'h06, rdata)
      wrr(ST, 8'hfb);
      rdr(ST, v);
      `CHK("underflow cleared", 8'h02, v)
      wrr(ST, 8'h00);
      rdr(ST, v);
      `CHK("tx irq cleared", 8'h00, v)
    end
    for (int j = 0; j < 2; j++) begin
      ow = j[0];
      sb = 8'($urandom);
      d = sb;
      wrr(TX, 8'($urandom));
      falls(8);
      sb = ~d;
      wrr(TX, 8'($urandom));
      falls(8);
      rdr(ST, v);
      `CHK("overflow status", st_exp(1'b1), v)
      rdr(RX, v);
      `CHK("overwrite", ow ? sb : d, v)
      rdr(ST, v);
      `CHK("overflow cleared", 8'h06, v)
      wrr(ST, 8'h00);
    end
    ssie = 1;
    wrr(TX, 8'h5a);
    falls(2);
    ss_ext = 0;
    falls(6);
    ss_ext = 1;
    rdr(ST, v);
    `CHK("multimaster error", 1'b1, v[6])
    wrr(ST, 8'hbf);
    rdr(ST, v);
    `CHK("multimaster cleared", 1'b0, v[6])
    ssie = 0;
    rdr(RX, v);
    wrr(ST, 8'h00);
    wrr(TX, 8'h11);
    falls(2);
    ims = 0;
    wrr(TX, 8'h22);
    falls(8);
    wrr(TX, 8'h33);
    falls(6);
    repeat (20) @(negedge clk);
    `CHK("halted select", 1'b1, ss_o)
    rdr(ST, v);
    `CHK("held tx data", 1'b1, v[0])
    wrr(ST, 8'hfe);
    rdr(ST, v);
    `CHK("tx full cleared", 1'b0, v[0])
    // A second reset in mid-run must clear the flags left by the halt.
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    rdr(ST, v);
    `CHK("status after second reset", ssf_pkg::STATUS_RESET, v)
    // One byte as slave, clocked by the bench as outside master.
    mm = 0;
    ims = 1;
    d = 8'($urandom);
    sb = 8'($urandom);
    wrr(TX, d);
    ss_ext = 0;
    repeat (4) @(negedge clk);
    rdr(ST, v);
    `CHK("slave busy", 1'b1, v[7])
    sbyte(sb, v);
    `CHK("slave out byte", d, v)
    repeat (4) @(negedge clk);
    rdr(ST, v);
    `CHK("slave status", 8'h9e, v)
    ss_ext = 1;
    rdr(RX, v);
    `CHK("slave in byte", sb, v)
    print_verdict();
  end
endmodule : ssf_spi_flags_tb
